// File: include/fscfe_pkg.sv
package fscfe_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] MEM_READ_CMD = 8'h03;
  localparam logic [7:0] MEM_WRITE_CMD = 8'h02;

  // ==========================================================
  // address layout
  localparam int ADDR_W = 13;
  localparam int ADDR_HI_W = ADDR_W - 8;

  // ==========================================================
  // status register layout
  localparam int WRITE_ENABLE_FLAG_BIT = 1;
  localparam int BP0_BIT = 2;
  localparam int BP1_BIT = 3;
  localparam int WPEN_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // only the protect-enable and block-protect bits take written data
  localparam logic [7:0] STATUS_WRITE_MASK = 8'h8c;
  localparam logic [7:0] STATUS_ZERO_MASK = 8'h71;

  // ==========================================================
  // pin synchroniser
  localparam int SYNC_PINS = 3;

  typedef enum {
    ST_IDLE,
    ST_CMD,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_DATA,
    ST_IGNORE
  } fscfe_state_t;

endpackage

// File: core/fscfe_sync.sv
`timescale 1ns/10ps
module fscfe_sync
  import fscfe_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous levels in, clean levels out
  input wire logic [fscfe_pkg::SYNC_PINS-1:0] d_i,
  output logic [fscfe_pkg::SYNC_PINS-1:0] q_o
);
  logic [SYNC_PINS-1:0] meta;

  // first stage feeds only the second; idle levels: select high, clock low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 3'h4;
      q_o <= 3'h4;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // fscfe_sync

// File: core/fscfe_shift.sv
`timescale 1ns/10ps
module fscfe_shift (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clr_i,
  input wire logic sample_i,
  input wire logic bit_i,
  // assembled byte
  output logic [7:0] byte_o,
  output logic done_o
);
  logic [2:0] cnt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr_i)
    begin
      cnt <= 3'h0;
      byte_o <= 8'h00;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (sample_i)
      begin
        byte_o <= {byte_o[6:0], bit_i};
        cnt <= cnt + 3'h1;
        done_o <= (cnt == 3'h7);
      end
    end
  end
endmodule // fscfe_shift

// File: core/fscfe_top.sv
// Contract
// - sample input on clock rise, change output on clock fall, both modes
// - clock level at select start picks mode 0 (low) or mode 3 (high)
// - in mode 3 the first rise after the clock went low carries bit one
// - while deselected, input is ignored and output is not driven
// - first eight bits after select are the command; address and data follow
// - one command per select; a new one needs a fresh select
// - all bytes travel most significant bit first, both directions
// - memory commands carry two address bytes; only the low 13 bits count
// - unknown command: do nothing, ignore input until reselect, output off
// - latch set is 06h, latch clear 04h, status read 05h
// - status write 01h, memory read 03h, memory write 02h; nothing else valid
// - write-enable flag clears at reset and sets on latch set command
// - status and memory writes are refused while the flag is clear
// - the data of a status write never changes the write-enable flag
// - flag clears at deselect ending latch clear, status write or memory write
// - status shows the flag; one means writes permitted
// - an 8-bit status register served by status read and status write
// - flag at status bit 1; bits 0 and 4 to 6 read zero
`timescale 1ns/10ps
module fscfe_top
  import fscfe_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // serial link
  input wire logic CS_N_I,
  input wire logic SCK_I,
  input wire logic SI_I,
  output logic SO_O,
  output logic SO_OE_O,
  // memory array port
  output logic [fscfe_pkg::ADDR_W-1:0] MEM_ADDR_O,
  output logic [7:0] MEM_WDATA_O,
  output logic MEM_WR_O,
  output logic MEM_RD_O,
  input wire logic [7:0] MEM_RDATA_I,
  // status
  output logic [7:0] STATUS_O,
  output logic MODE3_O
);
  import fscfe_pkg::*;

  // ==========================================================
  // pin sampling and edge detection
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic cs_d;
  logic sck_d;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  fscfe_sync u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .d_i({CS_N_I, SCK_I, SI_I}),
    .q_o({cs_s, sck_s, si_s})
  );

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      cs_d <= 1'b1;
      sck_d <= 1'b0;
    end
    else
    begin
      cs_d <= cs_s;
      sck_d <= sck_s;
    end
  end

  assign cs_fall = cs_d && !cs_s;
  assign cs_rise = !cs_d && cs_s;
  assign sck_rise = !sck_d && sck_s;
  assign sck_fall = sck_d && !sck_s;

  // ==========================================================
  // mode detection
  // armed stays low in mode 3 until the clock has dropped once, so the
  // idle-high level at select is never mistaken for a first rising edge
  logic armed;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      MODE3_O <= 1'b0;
      armed <= 1'b0;
    end
    else if (cs_fall)
    begin
      MODE3_O <= sck_s;
      armed <= !sck_s;
    end
    else if (sck_fall)
    begin
      armed <= 1'b1;
    end
  end

  // ==========================================================
  // receive shifter
  fscfe_state_t state;
  logic sample;
  logic [7:0] rx_byte;
  logic rx_done;

  // nothing is taken while deselected or after an unknown command
  assign sample = sck_rise && armed && !cs_s && !cs_fall
                  && (state != ST_IDLE) && (state != ST_IGNORE);

  fscfe_shift u_rx (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .clr_i(cs_fall),
    .sample_i(sample),
    .bit_i(si_s),
    .byte_o(rx_byte),
    .done_o(rx_done)
  );

  // ==========================================================
  // command decode
  logic [7:0] opcode;
  logic cmd_seen;
  logic rx_valid_cmd;
  logic cmd_clears_flag;

  assign rx_valid_cmd = (rx_byte == LATCH_SET_CMD) || (rx_byte == LATCH_CLEAR_CMD)
                        || (rx_byte == STATUS_READ_CMD) || (rx_byte == STATUS_WRITE_CMD)
                        || (rx_byte == MEM_READ_CMD) || (rx_byte == MEM_WRITE_CMD);
  assign cmd_clears_flag = cmd_seen && ((opcode == LATCH_CLEAR_CMD) || (opcode == STATUS_WRITE_CMD)
                           || (opcode == MEM_WRITE_CMD));

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      state <= ST_IDLE;
    end
    else if (cs_s)
    begin
      state <= ST_IDLE;
    end
    else if (cs_fall)
    begin
      state <= ST_CMD;
    end
    else if (rx_done)
    begin
      unique case (state)
        ST_CMD:
        begin
          if (!rx_valid_cmd)
            state <= ST_IGNORE;
          else if ((rx_byte == MEM_READ_CMD) || (rx_byte == MEM_WRITE_CMD))
            state <= ST_ADDR_HI;
          else if ((rx_byte == STATUS_READ_CMD) || (rx_byte == STATUS_WRITE_CMD))
            state <= ST_DATA;
          else
            state <= ST_IGNORE;
        end
        ST_ADDR_HI: state <= ST_ADDR_LO;
        ST_ADDR_LO: state <= ST_DATA;
        ST_DATA: state <= ST_DATA;
        ST_IDLE: state <= ST_IDLE;
        ST_IGNORE: state <= ST_IGNORE;
        default: state <= ST_IGNORE;
      endcase
    end
  end

  // a second command byte inside one select is address or data, or is ignored after a latch or unknown command; it is never decoded
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I || cs_fall)
    begin
      opcode <= 8'h00;
      cmd_seen <= 1'b0;
    end
    else if (rx_done && (state == ST_CMD))
    begin
      opcode <= rx_byte;
      cmd_seen <= rx_valid_cmd;
    end
  end

  // ==========================================================
  // status register
  logic status_done;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I || cs_fall)
      status_done <= 1'b0;
    else if (rx_done && (state == ST_DATA) && (opcode == STATUS_WRITE_CMD))
      status_done <= 1'b1;
  end

  // bits outside the write mask are never loaded from data; all of them but the flag hold zero for good
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      STATUS_O <= STATUS_RESET;
    end
    else
    begin
      if (rx_done && (state == ST_DATA) && (opcode == STATUS_WRITE_CMD) && !status_done
          && STATUS_O[WRITE_ENABLE_FLAG_BIT])
        STATUS_O <= (rx_byte & STATUS_WRITE_MASK) | (STATUS_O & ~STATUS_WRITE_MASK);
      if (cs_rise && cmd_clears_flag)
        STATUS_O[WRITE_ENABLE_FLAG_BIT] <= 1'b0;
      if (rx_done && (state == ST_CMD) && (rx_byte == LATCH_SET_CMD))
        STATUS_O[WRITE_ENABLE_FLAG_BIT] <= 1'b1;
    end
  end

  // ==========================================================
  // memory port
  // read data can land on the very fall that sends its first bit; the transmit side merges load and shift
  logic rd_wait;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      MEM_ADDR_O <= '0;
      MEM_WDATA_O <= 8'h00;
      MEM_WR_O <= 1'b0;
      MEM_RD_O <= 1'b0;
      rd_wait <= 1'b0;
    end
    else
    begin
      MEM_WR_O <= 1'b0;
      MEM_RD_O <= 1'b0;
      rd_wait <= MEM_RD_O;
      if (MEM_WR_O || rd_wait)
        MEM_ADDR_O <= MEM_ADDR_O + 13'h0001;
      if (rx_done && !cs_s)
      begin
        unique case (state)
          ST_ADDR_HI:
            MEM_ADDR_O[ADDR_W-1:8] <= rx_byte[ADDR_HI_W-1:0];
          ST_ADDR_LO:
          begin
            MEM_ADDR_O[7:0] <= rx_byte;
            MEM_RD_O <= (opcode == MEM_READ_CMD);
          end
          ST_DATA:
          begin
            if ((opcode == MEM_WRITE_CMD) && STATUS_O[WRITE_ENABLE_FLAG_BIT])
            begin
              MEM_WDATA_O <= rx_byte;
              MEM_WR_O <= 1'b1;
            end
            MEM_RD_O <= (opcode == MEM_READ_CMD);
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // transmit shifter
  logic [7:0] tx;
  logic tx_on;
  logic load_status;

  assign load_status = rx_done && (((state == ST_CMD) && (rx_byte == STATUS_READ_CMD))
                       || ((state == ST_DATA) && (opcode == STATUS_READ_CMD)));

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      tx <= 8'h00;
      tx_on <= 1'b0;
      SO_O <= 1'b0;
      SO_OE_O <= 1'b0;
    end
    else if (cs_s)
    begin
      tx_on <= 1'b0;
      SO_OE_O <= 1'b0;
    end
    else
    begin
      if (load_status)
      begin
        tx <= STATUS_O;
        tx_on <= 1'b1;
      end
      else if (sck_fall && (tx_on || rd_wait))
      begin
        SO_O <= rd_wait ? MEM_RDATA_I[7] : tx[7];
        tx <= rd_wait ? {MEM_RDATA_I[6:0], 1'b0} : {tx[6:0], 1'b0};
        tx_on <= 1'b1;
        SO_OE_O <= 1'b1;
      end
      else if (rd_wait)
      begin
        tx <= MEM_RDATA_I;
        tx_on <= 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking chk_cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence select_s;
    cs_d && !cs_s;
  endsequence

  sequence cmd_byte_s(logic [7:0] code);
    rx_done && (state == ST_CMD) && (rx_byte == code);
  endsequence

  mode_capture_a: assert property (select_s |=> (MODE3_O == $past(sck_s)))
    else $error("mode not taken from clock level at select");

  mode3_wait_a: assert property (select_s ##0 sck_s |=> !armed)
    else $error("mode 3 armed before clock went low");

  deselect_quiet_a: assert property (cs_s ##1 cs_s |-> !SO_OE_O && !sample)
    else $error("link active while deselected");

  out_on_fall_a: assert property ($changed(SO_O) |-> $past(sck_fall))
    else $error("output changed away from a falling clock edge");

  restart_a: assert property (select_s |=> (state == ST_CMD) && !cmd_seen)
    else $error("select did not restart decoding");

  invalid_silent_a: assert property (cmd_byte_s(8'h07) |=> (state == ST_IGNORE) ##1 !SO_OE_O)
    else $error("unknown command not ignored");

  flag_set_a: assert property (cmd_byte_s(LATCH_SET_CMD) |=> STATUS_O[WRITE_ENABLE_FLAG_BIT])
    else $error("latch set did not raise the flag");

  flag_clear_a: assert property (cs_rise && cmd_clears_flag |=> !STATUS_O[WRITE_ENABLE_FLAG_BIT])
    else $error("flag survived end of a write command");

  flag_kept_a: assert property (rx_done && (state == ST_DATA) && (opcode == STATUS_WRITE_CMD)
                                |=> $stable(STATUS_O[WRITE_ENABLE_FLAG_BIT]))
    else $error("status write changed the flag");

  write_refused_a: assert property (MEM_WR_O |-> $past(STATUS_O[WRITE_ENABLE_FLAG_BIT], 1))
    else $error("memory write without the flag");

  zero_bits_a: assert property ((STATUS_O & STATUS_ZERO_MASK) == 8'h00)
    else $error("fixed status bits not zero");

  addr_high_a: assert property (rx_done && (state == ST_ADDR_HI)
                                |=> MEM_ADDR_O[ADDR_W-1:8] == $past(rx_byte[4:0]))
    else $error("address high byte not trimmed to 13 bits");

endmodule // fscfe_top

// File: verif/fscfe_master.sv
`timescale 1ns/10ps
module fscfe_master (
  // clock
  input wire logic clk_i,
  // serial pins
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i
);
  // ==========================================================
  // bus master model, all pins change on falling clock edges
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic sel(input logic mode3);
    sck_o = mode3;
    tick(2);
    cs_n_o = 1'b0;
    tick(4);
  endtask

  // 5 cycles low and 3 high keeps the 400 ns period; data out is
  // taken just before the rise, after the device had 5 cycles
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck_o = 1'b0;
      si_o = tx[i];
      tick(5);
      rx[i] = so_i;
      sck_o = 1'b1;
      tick(3);
    end
  endtask

  task automatic desel(input logic mode3);
    tick(1);
    sck_o = mode3;
    tick(2);
    cs_n_o = 1'b1;
    // released data line must not keep showing the last bit
    si_o = ~si_o;
    tick(6);
  endtask
endmodule // fscfe_master

// File: verif/fscfe_top_tb.sv
`timescale 1ns/10ps
module fscfe_top_tb;
  import fscfe_pkg::*;
  typedef logic [7:0] fscfe_bq_t [$];
  logic clk, rst, cs_n, sck, si, so, so_oe, wr, rd, mode3, oe_seen;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, status, rx;
  logic [7:0] mem [0:8191];
  fscfe_bq_t rxq;
  wire so_pin = so_oe ? so : 1'bz;
  int bad_count = 0;
  int checks = 0;
  int wr_n = 0;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  fscfe_top dut (.REF_CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si), .SO_O(so),
    .SO_OE_O(so_oe), .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata), .MEM_WR_O(wr), .MEM_RD_O(rd),
    .MEM_RDATA_I(rdata), .STATUS_O(status), .MODE3_O(mode3));
  fscfe_master m (.clk_i(clk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_pin));

  // ==========================================================
  // array model: read data is ready the cycle after the strobe
  always @(posedge clk)
  begin
    if (wr === 1'b1)
    begin
      mem[addr] = wdata;
      wr_n++;
    end
    if (rd === 1'b1)
      rdata <= mem[addr];
    if (so_oe === 1'b1)
      oe_seen = 1'b1;
  end

  // ==========================================================
  // checking and access tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d, comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one select per call; received bytes land in rxq
  task automatic cmd(input logic mode3_sel, input fscfe_bq_t b);
    oe_seen = 1'b0;
    rxq.delete();
    m.sel(mode3_sel);
    foreach (b[i])
    begin
      m.xbyte(b[i], rx);
      rxq.push_back(rx);
    end
    m.desel(mode3_sel);
    chk({7'h00, so_oe}, 8'h00);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    rdata = 8'h00;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    m.tick(3);
    chk(status, STATUS_RESET);
    chk({7'h00, mode3}, 8'h00);
    cmd(1'b0, '{STATUS_WRITE_CMD, 8'hff});
    chk(status, 8'h00);
    cmd(1'b1, '{LATCH_SET_CMD});
    chk({7'h00, mode3}, 8'h01);
    chk(status, 8'h02);
    // only the first data byte counts
    cmd(1'b0, '{STATUS_WRITE_CMD, 8'hff, 8'h00});
    chk({7'h00, mode3}, 8'h00);
    chk(status, 8'h8c);
    cmd(1'b0, '{STATUS_READ_CMD, 8'h00, 8'h00});
    chk(rxq[1], 8'h8c);
    chk(rxq[2], 8'h8c);
    // the second code in the same select must be ignored
    cmd(1'b1, '{LATCH_SET_CMD, LATCH_CLEAR_CMD});
    chk(status, 8'h8e);
    cmd(1'b0, '{LATCH_CLEAR_CMD});
    chk(status, 8'h8c);
    wr_n = 0;
    cmd(1'b0, '{MEM_WRITE_CMD, 8'h00, 8'h10, 8'h77});
    chk(wr_n[7:0], 8'h00);
    cmd(1'b0, '{LATCH_SET_CMD});
    // ignored top address bits set on purpose; burst wraps past the end
    cmd(1'b1, '{MEM_WRITE_CMD, 8'hff, 8'hfe, 8'ha5, 8'h3c, 8'h5a});
    chk(wr_n[7:0], 8'h03);
    chk(mem[13'h1ffe], 8'ha5);
    chk(mem[13'h1fff], 8'h3c);
    chk(mem[13'h0000], 8'h5a);
    chk(status, 8'h8c);
    cmd(1'b1, '{MEM_READ_CMD, 8'h1f, 8'hfe, 8'h00, 8'h00, 8'h00});
    chk(rxq[3], 8'ha5);
    chk(rxq[4], 8'h3c);
    chk(rxq[5], 8'h5a);
    cmd(1'b0, '{8'h07, STATUS_READ_CMD, 8'h00});
    chk({7'h00, oe_seen}, 8'h00);
    chk(status, 8'h8c);
    cmd(1'b0, '{STATUS_READ_CMD, 8'h00});
    chk(rxq[1], 8'h8c);
    report_and_stop;
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end
endmodule // fscfe_top_tb
